// >>> logic/dpsc_cfg.svh
// Constants: register indices, field positions and reset values of the service block
// How it works
// [R01] A 16-bit host-alive counter reloads from a host value and counts down per exchange.
// [R02] Counter reaching zero returns slave to await-parameter and drops the master.
// [R03] Rearm bit set: next exchange telegram reloads the counter, then hardware clears rearm.
// [R04] Host sets rearm at power-up and periodically before the counter expires.
// [R05] Valid group-control telegram stores byte one in cell 3CH; group byte checked inside.
// [R06] Mode bit 8 picks interrupt on every group-control telegram or only on change.
// [R07] Host writes 00H into the group-control cell at power-up.
// [R08] Host enables Sync and Freeze in the first mode register before use.
// [R09] Command bits: Sync 5, Unsync 4, Freeze 3, Unfreeze 2, Clear_Data 1.
// [R10] Sync moves output transfer buffer onward; later outputs wait for next Sync.
// [R11] Input read request moves next input buffer to transfer only when new data exists.
// [R12] While freeze is active no input buffer exchange happens before sending.
// [R13] Output read request sends the host-held output buffer, sampled anew on each request.
// [R14] Host zero-fills its held output buffer during start-up.
// [R15] Configuration swap enable exchanges configuration and read-configuration buffers.
// [R16] Host issues go-offline when configuration changes during operation.
// [R17] Status byte 7: DPV1 7, Fail_Safe 6, Publisher 5, WD_Base 2, stop 1, start 0.
// [R18] Byte 8: alarm enables 7..2, zero 1, check mode 0; byte 9 fields as listed.
// [R19] Slave needs fail-safe but master lacks it: parameter fault flag is set; the code sets it only when DPV1 bit 7 is also set.
// [R20] Host packs structured parameter blocks and flags that with the structure bit.
// [R21] Host sets redundancy-command-supported in the first mode register.
// [R22] Clear_Data, power-up or drop-master clears the output transfer buffer and moves it.
// [R23] Host input swap command moves the host input buffer to the next position.
// [R24] Swap command read returns zeros in 7..4 and new host slot 01, 10 or 11.
`ifndef DPSC_CFG_SVH
`define DPSC_CFG_SVH
// Register word indices, byte address is four times the index
`define DPSC_IDX_DIN_SM     6'h08
`define DPSC_IDX_DIN_CMD    6'h09
`define DPSC_IDX_MODE0      6'h10
`define DPSC_IDX_MODE1      6'h11
`define DPSC_IDX_MODE2      6'h12
`define DPSC_IDX_HA_RELOAD  6'h13
`define DPSC_IDX_HA_COUNT   6'h14
`define DPSC_IDX_STATUS     6'h15
`define DPSC_IDX_PRM_EXT    6'h16
`define DPSC_IDX_GROUP      6'h17
`define DPSC_IDX_GC_CELL    6'h3C
// Mode bits
`define DPSC_M0_SYNC_EN     0
`define DPSC_M0_FREEZE_EN   1
`define DPSC_M0_FAILSAFE    2
`define DPSC_M0_REDUND      3
`define DPSC_M1_REARM       0
`define DPSC_M1_CFG_SWAP    1
`define DPSC_M1_GO_OFFLINE  2
`define DPSC_M2_GC_CHANGE   8
// Group-control command bits
`define DPSC_GC_SYNC        5
`define DPSC_GC_UNSYNC      4
`define DPSC_GC_FREEZE      3
`define DPSC_GC_UNFREEZE    2
`define DPSC_GC_CLEAR       1
// Parameter status bytes 7..9 packed as {byte9, byte8, byte7}
`define DPSC_P7_DPV1_EN     7
`define DPSC_P7_FAIL_SAFE   6
`define DPSC_P8_ZERO_BIT    9
`define DPSC_P9_STRUCT      19
// Reset values
`define DPSC_RST_RELOAD     16'hFFFF
`define DPSC_RST_COUNT      16'hFFFF
`define DPSC_SLOT_NIL       2'h0
`endif

// >>> logic/dpsc_pkg.sv
// Types shared by the service block modules
package dpsc_pkg;
    typedef enum logic [0:0] {AWAIT_PRM, CYCLIC_EXCH} dpsc_slave_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic        expired;
    } dpsc_wd_t;
    typedef struct packed {
        logic [1:0] f_slot;
        logic [1:0] u_slot;
        logic [1:0] n_slot;
        logic [1:0] d_slot;
    } dpsc_din_t;
endpackage

// >>> logic/dpsc_links.sv
// Interfaces between the service core and its watchdog and input buffer helpers
`timescale 1ns/1ps
`default_nettype none
interface dpsc_wd_if;
    logic        dx;
    logic        rearm;
    logic [15:0] reload;
    logic        rearm_clr;
    logic        expired;
    logic [15:0] count;
    modport core (output dx, rearm, reload, input rearm_clr, expired, count);
    modport wdog (input dx, rearm, reload, output rearm_clr, expired, count);
endinterface
interface dpsc_din_if;
    logic       swap;
    logic       fetch;
    logic [1:0] preview;
    logic [7:0] sm;
    logic [1:0] send_slot;
    modport core (output swap, fetch, input preview, sm, send_slot);
    modport bufs (input swap, fetch, output preview, sm, send_slot);
endinterface
`default_nettype wire

// >>> logic/dpsc_watchdog.sv
// Host-alive counter decremented by cyclic exchange telegrams
`timescale 1ns/1ps
`include "dpsc_cfg.svh"
`default_nettype none
module dpsc_watchdog (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Core side
    dpsc_wd_if.wdog   wd
);
    dpsc_pkg::dpsc_wd_t st;
    dpsc_pkg::dpsc_wd_t next_st;

    // Reload on rearm, otherwise count down to zero
    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        if (wd.dx) begin
            if (wd.rearm) begin
                next_st.cnt = wd.reload; // see [R03]
            end else if (st.cnt != 16'h0000) begin
                next_st.cnt = st.cnt - 16'h0001; // see [R01]
                next_st.expired = (st.cnt == 16'h0001); // see [R02]
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{cnt: `DPSC_RST_COUNT, expired: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs to the core
    assign wd.rearm_clr = wd.dx & wd.rearm;
    assign wd.expired   = st.expired;
    assign wd.count     = st.cnt;
endmodule // dpsc_watchdog
`default_nettype wire

// >>> logic/dpsc_din_bufs.sv
// Input buffer slot rotation among host, next, transfer and free positions
`timescale 1ns/1ps
`include "dpsc_cfg.svh"
`default_nettype none
module dpsc_din_bufs (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Core side
    dpsc_din_if.bufs  din
);
    dpsc_pkg::dpsc_din_t st;
    dpsc_pkg::dpsc_din_t next_st;

    // Host swap first, then fetch of a pending next buffer
    always_comb begin
        next_st = st;
        if (din.swap) begin
            next_st.u_slot = (st.n_slot != `DPSC_SLOT_NIL) ? st.n_slot : st.f_slot; // see [R23]
            next_st.f_slot = (st.n_slot != `DPSC_SLOT_NIL) ? st.f_slot : `DPSC_SLOT_NIL;
            next_st.n_slot = st.u_slot;
        end
        if (din.fetch && next_st.n_slot != `DPSC_SLOT_NIL) begin
            next_st.f_slot = next_st.d_slot; // see [R11]
            next_st.d_slot = next_st.n_slot;
            next_st.n_slot = `DPSC_SLOT_NIL;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{f_slot: 2'h3, u_slot: 2'h1, n_slot: 2'h0, d_slot: 2'h2};
        end else begin
            st <= next_st;
        end
    end

    // Slot views for the core
    assign din.preview   = (st.n_slot != `DPSC_SLOT_NIL) ? st.n_slot : st.f_slot; // see [R24]
    assign din.sm        = {st.f_slot, st.u_slot, st.n_slot, st.d_slot};
    assign din.send_slot = st.d_slot;
endmodule // dpsc_din_bufs
`default_nettype wire

// >>> logic/dpsc_core.sv
// Service core: register slave, group-control, host-alive, buffer and parameter handling
`timescale 1ns/1ps
`include "dpsc_cfg.svh"
`default_nettype none
module dpsc_core (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Avalon-MM register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Telegram events from the bus receiver
    input  wire logic        dx_rx,
    input  wire logic        gc_rx,
    input  wire logic [7:0]  gc_cmd,
    input  wire logic [7:0]  gc_group,
    input  wire logic        rd_input_req,
    input  wire logic        rd_output_req,
    input  wire logic        prm_rx,
    input  wire logic [23:0] prm_status,
    input  wire logic        enter_exchange,
    // Output buffer handling
    input  wire logic [1:0]  dout_user_slot,
    output logic [1:0]       dout_send_slot,
    output logic             out_move,
    output logic             out_clear,
    // Input and configuration buffers
    output logic [1:0]       din_send_slot,
    output logic             cfg_swap,
    output logic             read_cfg_slot,
    // Slave state and events
    output logic             cyclic_exchange_state,
    output logic             drop_master_action,
    output logic             group_ctrl_irq,
    output logic             prm_fault
);
    typedef struct packed {
        logic                 wreq;
        logic [31:0]          rdata;
        logic [7:0]           gc_cell;
        logic [7:0]           gc_prev;
        logic                 gc_seen;
        logic [3:0]           mode0;
        logic [2:0]           mode1;
        logic                 mode2_chg;
        logic [15:0]          reload;
        logic [7:0]           group;
        logic [23:0]          prm;
        logic                 prm_fault;
        logic                 sync_mode;
        logic                 freeze_mode;
        dpsc_pkg::dpsc_slave_t slave;
        logic                 cfg_sel;
        logic                 cfg_swap;
        logic                 drop;
        logic                 out_move;
        logic                 out_clear;
        logic                 gc_irq;
        logic [1:0]           dout_slot;
        logic                 pwr_init;
    } dpsc_core_t;

    dpsc_core_t st;
    dpsc_core_t next_st;

    dpsc_wd_if  wd ();
    dpsc_din_if din ();

    // Helpers
    dpsc_watchdog u_wdog (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wd       (wd.wdog)
    );
    dpsc_din_bufs u_din (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      (din.bufs)
    );

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] wd_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus decode
    logic       req;
    logic       prep;
    logic       acc;
    logic       aligned;
    logic [5:0] idx;
    logic       wr;
    logic       gc_ok;
    logic       exch;
    logic [31:0] wmrg;

    assign req     = avs_read | avs_write;
    assign prep    = req & st.wreq;
    assign acc     = req & ~st.wreq;
    assign aligned = (avs_address[1:0] == 2'h0);
    assign idx     = avs_address[7:2];
    assign wr      = acc & avs_write & aligned;
    assign exch    = (st.slave == dpsc_pkg::CYCLIC_EXCH);
    assign gc_ok   = gc_rx & ((gc_group == 8'h00) | ((gc_group & st.group) != 8'h00)); // see [R05]

    // Helper inputs
    assign wd.dx     = dx_rx & exch;
    assign wd.rearm  = st.mode1[`DPSC_M1_REARM];
    assign wd.reload = st.reload;
    assign din.swap  = acc & avs_read & aligned & (idx == `DPSC_IDX_DIN_CMD); // see [R23]
    assign din.fetch = (rd_input_req | dx_rx | (gc_ok & gc_cmd[`DPSC_GC_FREEZE]))
                       & ~st.freeze_mode; // see [R12]

    // Read data mux
    function automatic logic [31:0] rd_mux(input dpsc_core_t s, input logic [5:0] i,
                                           input logic [1:0] pv, input logic [7:0] sm,
                                           input logic [15:0] cnt);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (i)
            `DPSC_IDX_DIN_SM:    r[7:0] = sm;
            `DPSC_IDX_DIN_CMD:   r[1:0] = pv; // see [R24]
            `DPSC_IDX_MODE0:     r[3:0] = s.mode0;
            `DPSC_IDX_MODE1:     r[2:0] = s.mode1;
            `DPSC_IDX_MODE2:     r[`DPSC_M2_GC_CHANGE] = s.mode2_chg;
            `DPSC_IDX_HA_RELOAD: r[15:0] = s.reload;
            `DPSC_IDX_HA_COUNT:  r[15:0] = cnt;
            `DPSC_IDX_STATUS:    r[4:0] = {s.cfg_sel, s.prm_fault, s.freeze_mode,
                                           s.sync_mode, (s.slave == dpsc_pkg::CYCLIC_EXCH)};
            `DPSC_IDX_PRM_EXT:   r[23:0] = s.prm;
            `DPSC_IDX_GROUP:     r[7:0] = s.group;
            `DPSC_IDX_GC_CELL:   r[7:0] = s.gc_cell;
            default:             r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Next-state logic
    always_comb begin
        next_st = st;
        wmrg = merge(32'h0000_0000, avs_writedata, avs_byteenable);
        next_st.wreq      = ~prep;
        next_st.cfg_swap  = 1'b0;
        next_st.drop      = 1'b0;
        next_st.out_move  = 1'b0;
        next_st.out_clear = 1'b0;
        next_st.gc_irq    = 1'b0;
        next_st.pwr_init  = 1'b0;

        // Read data prepared one cycle before the accepting edge
        if (prep) begin
            next_st.rdata = (avs_read & aligned) ?
                            rd_mux(st, idx, din.preview, din.sm, wd.count) : 32'h0000_0000;
        end

        // Software writes
        if (wr) begin
            unique case (idx)
                `DPSC_IDX_MODE0: begin
                    wmrg = merge({28'h0, st.mode0}, avs_writedata, avs_byteenable);
                    next_st.mode0 = wmrg[3:0];
                end
                `DPSC_IDX_MODE1: begin
                    wmrg = merge({29'h0, st.mode1}, avs_writedata, avs_byteenable);
                    next_st.mode1 = wmrg[2:0];
                end
                `DPSC_IDX_MODE2: begin
                    if (avs_byteenable[1]) begin
                        next_st.mode2_chg = avs_writedata[`DPSC_M2_GC_CHANGE];
                    end
                end
                `DPSC_IDX_HA_RELOAD: begin
                    wmrg = merge({16'h0, st.reload}, avs_writedata, avs_byteenable);
                    next_st.reload = wmrg[15:0];
                end
                `DPSC_IDX_STATUS: begin
                    if (avs_byteenable[0] && avs_writedata[3]) begin
                        next_st.prm_fault = 1'b0;
                    end
                end
                `DPSC_IDX_GROUP: begin
                    if (avs_byteenable[0]) begin
                        next_st.group = avs_writedata[7:0];
                    end
                end
                `DPSC_IDX_GC_CELL: begin
                    if (avs_byteenable[0]) begin
                        next_st.gc_cell = avs_writedata[7:0];
                    end
                end
                default: begin
                    next_st.group = st.group;
                end
            endcase
        end

        // Rearm cleared by hardware unless software rewrites mode 1 in the same cycle
        if (wd.rearm_clr && !(wr && idx == `DPSC_IDX_MODE1)) begin
            next_st.mode1[`DPSC_M1_REARM] = 1'b0; // see [R03]
        end

        // Configuration buffer exchange
        if (st.mode1[`DPSC_M1_CFG_SWAP] && !(wr && idx == `DPSC_IDX_MODE1)) begin
            next_st.mode1[`DPSC_M1_CFG_SWAP] = 1'b0; // see [R15]
            next_st.cfg_swap = 1'b1;
            next_st.cfg_sel  = ~st.cfg_sel;
        end

        // Cyclic output data moves unless sync mode holds it
        if (dx_rx && exch && !st.sync_mode) begin
            next_st.out_move = 1'b1; // see [R10]
        end

        // Group-control telegram: store, decode commands, raise interrupt
        if (gc_ok) begin
            next_st.gc_cell = gc_cmd; // see [R05]
            next_st.gc_prev = gc_cmd;
            next_st.gc_seen = 1'b1;
            next_st.gc_irq  = ~st.mode2_chg | ~st.gc_seen | (gc_cmd != st.gc_prev); // see [R06]
            if (st.mode0[`DPSC_M0_SYNC_EN]) begin
                if (gc_cmd[`DPSC_GC_SYNC]) begin
                    next_st.sync_mode = 1'b1; // see [R09]
                    next_st.out_move  = 1'b1; // see [R10]
                end else if (gc_cmd[`DPSC_GC_UNSYNC]) begin
                    next_st.sync_mode = 1'b0; // see [R10]
                    next_st.out_move  = 1'b1;
                end
            end
            if (st.mode0[`DPSC_M0_FREEZE_EN]) begin
                if (gc_cmd[`DPSC_GC_FREEZE]) begin
                    next_st.freeze_mode = 1'b1; // see [R09]
                end else if (gc_cmd[`DPSC_GC_UNFREEZE]) begin
                    next_st.freeze_mode = 1'b0;
                end
            end
            if (gc_cmd[`DPSC_GC_CLEAR]) begin
                next_st.out_clear = 1'b1; // see [R22]
                next_st.out_move  = 1'b1;
            end
        end

        // Output read request samples the host-held buffer every time
        if (rd_output_req) begin
            next_st.dout_slot = dout_user_slot; // see [R13]
        end

        // Parameter status bytes and fail-safe check
        if (prm_rx) begin
            next_st.prm = prm_status; // see [R17]
            next_st.prm[`DPSC_P8_ZERO_BIT] = 1'b0; // see [R18]
            if (prm_status[`DPSC_P7_DPV1_EN] && st.mode0[`DPSC_M0_FAILSAFE]
                && !prm_status[`DPSC_P7_FAIL_SAFE]) begin
                next_st.prm_fault = 1'b1; // see [R19]
            end
        end

        // Slave state: enter exchange, leave on expiry or go-offline
        if (enter_exchange) begin
            next_st.slave = dpsc_pkg::CYCLIC_EXCH;
        end
        if (st.mode1[`DPSC_M1_GO_OFFLINE]) begin
            next_st.mode1[`DPSC_M1_GO_OFFLINE] = 1'b0;
            next_st.slave = dpsc_pkg::AWAIT_PRM;
            next_st.drop  = exch;
        end
        if (wd.expired) begin
            next_st.slave = dpsc_pkg::AWAIT_PRM; // see [R02]
            next_st.drop  = 1'b1;
        end
        if (next_st.drop || st.pwr_init) begin
            next_st.out_clear = 1'b1; // see [R22]
            next_st.out_move  = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{wreq: 1'b1, reload: `DPSC_RST_RELOAD, slave: dpsc_pkg::AWAIT_PRM,
                    pwr_init: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata          = st.rdata;
    assign avs_waitrequest       = st.wreq;
    assign dout_send_slot        = st.dout_slot;
    assign out_move              = st.out_move;
    assign out_clear             = st.out_clear;
    assign din_send_slot         = din.send_slot;
    assign cfg_swap              = st.cfg_swap;
    assign read_cfg_slot         = st.cfg_sel;
    assign cyclic_exchange_state = exch;
    assign drop_master_action    = st.drop;
    assign group_ctrl_irq        = st.gc_irq;
    assign prm_fault             = st.prm_fault;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_wd_reload: assert property (wd.dx && wd.rearm |=> wd.count == $past(st.reload)) // see [R01]
        else $error("host-alive counter not reloaded");
    a_rearm_clear: assert property (wd.rearm_clr && !wr |=> !st.mode1[0]) // see [R03]
        else $error("rearm bit not cleared");
    a_drop_expire: assert property (wd.expired |=> drop_master_action && !exch) // see [R02]
        else $error("expiry did not drop master");
    a_gc_store: assert property (gc_ok |=> st.gc_cell == $past(gc_cmd)) // see [R05]
        else $error("group command not stored");
    a_gc_irq_every: assert property (gc_ok && !st.mode2_chg |=> group_ctrl_irq) // see [R06]
        else $error("group interrupt missing");
    a_gc_irq_same: assert property (gc_ok && st.mode2_chg && st.gc_seen
        && gc_cmd == st.gc_prev |=> !group_ctrl_irq) // see [R06]
        else $error("group interrupt on unchanged command");
    a_sync_hold: assert property (st.sync_mode && !gc_ok && !wd.expired && !st.pwr_init
        && !st.mode1[2] |=> !out_move) // see [R10]
        else $error("output moved in sync mode");
    a_freeze_nofetch: assert property (st.freeze_mode |=> $stable(din.send_slot)) // see [R12]
        else $error("input fetched while frozen");
    a_clear_data: assert property (gc_ok && gc_cmd[1] |=> out_clear && out_move) // see [R22]
        else $error("clear data not performed");
    a_swap_code: assert property (prep && avs_read && aligned && idx == `DPSC_IDX_DIN_CMD
        |=> st.rdata[31:2] == 30'h0 && st.rdata[1:0] != 2'h0) // see [R24]
        else $error("bad swap command code");
    a_prm_fault: assert property (prm_rx && prm_status[7] && !prm_status[6] && st.mode0[2]
        |=> prm_fault) // see [R19]
        else $error("fail-safe mismatch not flagged");
    a_rdout_slot: assert property (rd_output_req // see [R13]
        |=> dout_send_slot == $past(dout_user_slot))
        else $error("output read slot wrong");
    a_bus_answer: assert property (prep |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    c_expire: cover property (wd.dx ##[1:20] wd.expired);
    c_sync_cycle: cover property (gc_ok && gc_cmd[5] ##[1:50] gc_ok && gc_cmd[4]);
    c_swap_read: cover property (din.swap ##[1:20] rd_input_req);
    c_cfg_swap: cover property (cfg_swap);
endmodule // dpsc_core
`default_nettype wire

// >>> tb/dpsc_dp_master.sv
// DP master stand-in that raises telegram events at the core
`timescale 1ns/1ps
`default_nettype none
module dpsc_dp_master (
    // Clock
    input  wire logic   core_clk,
    // Events: dx, gc, rd_in, rd_out, prm, enter
    output logic [5:0]  ev,
    output logic [7:0]  gc_cmd,
    output logic [7:0]  gc_group,
    output logic [23:0] prm_status
);
    // Idle bus with broadcast group select
    initial begin
        ev = 6'h00;
        gc_cmd = 8'h00;
        gc_group = 8'h00;
        prm_status = 24'h000000;
    end
    // One-cycle telegram; data inverted once released so stale values never match
    task send(input int k, input logic [7:0] c, input logic [23:0] p);
        @(posedge core_clk);
        ev[k] <= 1'b1;
        gc_cmd <= c;
        prm_status <= p;
        @(posedge core_clk);
        ev <= 6'h00;
        gc_cmd <= ~c;
        prm_status <= ~p;
    endtask
endmodule // dpsc_dp_master
`default_nettype wire

// >>> tb/tb_top.sv
// Register and telegram level testbench of the service core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, cyclic_exchange_state, drop_master_action;
    logic        group_ctrl_irq, prm_fault;
    logic [1:0]  dout_user_slot = 2'h1;
    logic [1:0]  dout_send_slot;
    logic [5:0]  ev;
    logic [7:0]  gc_cmd, gc_group;
    logic [23:0] prm_status;
    int          fail_count = 0, compares = 0, n_drop = 0, n_irq = 0;
    // Clock and event pulse counters
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (drop_master_action === 1'b1) n_drop++;
        if (group_ctrl_irq === 1'b1) n_irq++;
    end
    dpsc_dp_master pm (.core_clk, .ev, .gc_cmd, .gc_group, .prm_status);
    dpsc_core dut (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .dx_rx(ev[0]), .gc_rx(ev[1]), .gc_cmd, .gc_group, .rd_input_req(ev[2]),
        .rd_output_req(ev[3]), .prm_rx(ev[4]), .prm_status, .enter_exchange(ev[5]),
        .dout_user_slot, .dout_send_slot, .out_move(), .out_clear(), .din_send_slot(),
        .cfg_swap(), .read_cfg_slot(), .cyclic_exchange_state, .drop_master_action,
        .group_ctrl_irq, .prm_fault);
    // Report counts and verdict, then stop
    task give_verdict;
        $display("mismatches %0d of %0d checks", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Compare one value
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // Avalon access held until waitrequest is sampled low; read data lands in q
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40) begin
            fail_count++;
            give_verdict;
        end
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(0, 8'h4C, 0);
        chk("reload", 32'h0000FFFF, q);
        bus(1, 8'hF0, 0);
        bus(0, 8'h30, 0);
        chk("unmapped", 32'h0, q);
        bus(1, 8'h4C, 32'h3);
        bus(1, 8'h44, 32'h1);
        pm.send(5, 0, 0);
        pm.send(0, 0, 0);
        chk("exch", 32'h1, {31'h0, cyclic_exchange_state});
        bus(0, 8'h50, 0);
        chk("count", 32'h3, q);
        bus(0, 8'h44, 0);
        chk("rearm", 32'h0, q);
        pm.send(0, 0, 0);
        pm.send(0, 0, 0);
        bus(0, 8'h50, 0);
        chk("count", 32'h1, q);
        pm.send(0, 0, 0);
        repeat (4) @(posedge core_clk);
        chk("drop", 32'h1, n_drop);
        chk("exch", 32'h0, {31'h0, cyclic_exchange_state});
        bus(1, 8'h40, 32'hF);
        for (int i = 1; i < 6; i++) begin
            pm.send(1, 8'h01 << i, 0);
            bus(0, 8'hF0, 0);
            chk("cell", 32'h1 << i, q);
        end
        bus(1, 8'h48, 32'h100);
        pm.send(1, 8'h20, 0);
        pm.send(1, 8'h02, 0);
        repeat (3) @(posedge core_clk);
        chk("irq", 32'h6, n_irq);
        // Sync and freeze both latched by the loop above
        bus(0, 8'h54, 0);
        chk("status", 32'h6, q);
        bus(0, 8'h24, 0);
        chk("swap", 32'h1, {31'h0, q[31:2] === 30'h0 && q[1:0] !== 2'h0});
        // Frozen input read keeps the transfer slot, unfrozen one fetches
        pm.send(2, 0, 0);
        bus(0, 8'h20, 0);
        chk("din_sm", 32'h36, q);
        pm.send(1, 8'h04, 0);
        pm.send(2, 0, 0);
        bus(0, 8'h20, 0);
        chk("din_sm", 32'hB1, q);
        bus(1, 8'h40, 32'h4);
        pm.send(4, 0, 24'hFFFF80);
        bus(0, 8'h58, 0);
        chk("prm", 32'hFFFD80, q);
        chk("fault", 32'h1, {31'h0, prm_fault});
        bus(1, 8'h44, 32'h2);
        bus(0, 8'h54, 0);
        chk("status", 32'h1A, q);
        dout_user_slot <= 2'h2;
        pm.send(3, 0, 0);
        repeat (2) @(posedge core_clk);
        chk("dout", 32'h2, {30'h0, dout_send_slot});
        dout_user_slot <= 2'h3;
        pm.send(3, 0, 0);
        repeat (2) @(posedge core_clk);
        chk("dout", 32'h3, {30'h0, dout_send_slot});
        // Go offline from data exchange drops the master
        pm.send(5, 0, 0);
        bus(1, 8'h44, 32'h4);
        repeat (3) @(posedge core_clk);
        chk("drop", 32'h2, n_drop);
        chk("exch", 32'h0, {31'h0, cyclic_exchange_state});
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
